// [design/fsq_defines.svh]
// constants for the flash status and query readout host controller
// =====================================================================
// Overview of operation
// - done shows true bit; read program address
// - erase shows poll zero, window one, busy
// - poll buffered program at last buffer address
// - one extra read after poll shows true
`ifndef FSQ_DEFINES_SVH
`define FSQ_DEFINES_SVH
`define FSQ_CLK_NS        4
`define FSQ_RD_NS         100
`define FSQ_RD_CYC        ((`FSQ_RD_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
`define FSQ_WR_NS         60
`define FSQ_WR_CYC        ((`FSQ_WR_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)
`define FSQ_POLL_LIMIT    32'h00FFFFFF
// register byte offsets
`define FSQ_R_CTRL        12'h000
`define FSQ_R_ADDR        12'h004
`define FSQ_R_WDATA       12'h008
`define FSQ_R_STAT        12'h00C
`define FSQ_R_RDATA       12'h010
`define FSQ_R_POLLD       12'h014
// ctrl command codes
`define FSQ_C_READ        3'h1
`define FSQ_C_WRITE       3'h2
`define FSQ_C_POLL        3'h3
`define FSQ_C_TOGGLE      3'h4
// status bit positions of the flash data word
`define FSQ_B_POLL        7
`define FSQ_B_TOGGLE      6
`define FSQ_B_TIMEOUT     5
`define FSQ_B_WINDOW      3
`define FSQ_B_SECTOG      2
`define FSQ_B_ABORT       1
// query offsets and expected values
`define FSQ_Q_SIZE        8'h27
`define FSQ_V_SIZE        16'h0018
`define FSQ_Q_IFACE       8'h28
`define FSQ_V_IFACE       16'h0002
`define FSQ_Q_WBUF        8'h2A
`define FSQ_V_WBUF        16'h0005
`define FSQ_Q_NREG        8'h2C
`define FSQ_V_NREG        16'h0002
`define FSQ_Q_PRI         8'h40
`define FSQ_V_PRI_P       16'h0050
`define FSQ_Q_MAJ         8'h43
`define FSQ_V_MAJ         16'h0031
`define FSQ_V_MIN         16'h0033
`define FSQ_Q_ACCMIN      8'h4D
`define FSQ_V_ACCMIN      16'h00B5
`define FSQ_V_ACCMAX      16'h00C5
`define FSQ_Q_BOOT        8'h4F
`define FSQ_Q_PSUSP       8'h50
`define FSQ_V_PSUSP       16'h0001
`endif

// [design/fsq_pkg.sv]
// types shared by the flash status and query host controller
package fsq_pkg;
   typedef enum logic [2:0] {
      FSQ_IDLE,
      FSQ_SETUP,
      FSQ_STROBE,
      FSQ_HOLD,
      FSQ_CHECK
   } fsq_state_e;
   typedef enum logic [1:0] {
      FSQ_RES_OK,
      FSQ_RES_TIMEOUT,
      FSQ_RES_ABORT,
      FSQ_RES_LIMIT
   } fsq_result_e;
endpackage : fsq_pkg

// [design/fsq_sync.sv]
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module fsq_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,  // clock
   input  wire logic             rst,       // sync reset
   input  wire logic             clkEn,     // clock enable
   input  wire logic [WIDTH-1:0] asyncIn,   // pin level
   output logic      [WIDTH-1:0] syncOut    // synchronised level
);
   logic [WIDTH-1:0] meta_q;
   initial begin
      if (WIDTH < 1) $error("fsq_sync: WIDTH must be positive");
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q  <= '0;
         syncOut <= '0;
      end else if (clkEn) begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule : fsq_sync

// [design/fsq_host.sv]
// host controller: AXI4-Lite registers driving flash pins, status polling
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fsq_defines.svh"
module fsq_host #(
   parameter int          AW         = 24,             // flash address width
   parameter logic [31:0] POLL_LIMIT = `FSQ_POLL_LIMIT // reads before giving up
) (
   input  wire logic          core_clk,       // 250 MHz clock
   input  wire logic          rst,            // sync reset, high
   input  wire logic          clkEn,          // freezes state when low
   input  wire logic [11:0]   s_axi_awaddr,   // write address
   input  wire logic          s_axi_awvalid,  // write address valid
   output logic               s_axi_awready,  // write address ready
   input  wire logic [31:0]   s_axi_wdata,    // write data
   input  wire logic [3:0]    s_axi_wstrb,    // write strobes
   input  wire logic          s_axi_wvalid,   // write data valid
   output logic               s_axi_wready,   // write data ready
   output logic [1:0]         s_axi_bresp,    // write response
   output logic               s_axi_bvalid,   // write response valid
   input  wire logic          s_axi_bready,   // write response ready
   input  wire logic [11:0]   s_axi_araddr,   // read address
   input  wire logic          s_axi_arvalid,  // read address valid
   output logic               s_axi_arready,  // read address ready
   output logic [31:0]        s_axi_rdata,    // read data
   output logic [1:0]         s_axi_rresp,    // read response
   output logic               s_axi_rvalid,   // read data valid
   input  wire logic          s_axi_rready,   // read data ready
   output logic [AW-1:0]      flashAddr,      // flash address pins
   output logic               chipSel_n,      // chip select, low
   output logic               outEn_n,        // output enable, low
   output logic               wrStrobe_n,     // write strobe, low
   output logic [15:0]        dataOut,        // data bus drive value
   output logic               dataOe,         // high while host drives bus
   input  wire logic [15:0]   dataIn,         // data bus level
   input  wire logic          ready_busy_n    // open-drain ready/busy pin
);
   logic [15:0]           dataSync;
   logic                  rbSync;
   fsq_pkg::fsq_state_e   state_q;
   logic [2:0]            cmd_q;
   logic [7:0]            cnt_q;
   logic [31:0]           polls_q;
   logic                  busy_q;
   logic                  done_q;
   fsq_pkg::fsq_result_e  result_q;
   logic [AW-1:0]         addr_q;
   logic [15:0]           wdata_q;
   logic [15:0]           rdata_q;
   logic [15:0]           prev_q;
   logic                  havePrev_q;
   logic                  confirm_q;
   logic                  awHeld_q;
   logic                  wHeld_q;
   logic [11:0]           awAddr_q;
   logic [31:0]           wData_q;
   logic                  wrGo;
   logic                  startCmd;

   initial begin
      if (AW < 8 || AW > 32) $error("fsq_host: AW out of range");
   end

   // =================================================================
   // pin synchronisers
   fsq_sync #(.WIDTH(17)) u_fsq_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .clkEn    (clkEn),
      .asyncIn  ({ready_busy_n, dataIn}),
      .syncOut  ({rbSync, dataSync})
   );

   // =================================================================
   // AXI4-Lite write side
   assign wrGo = awHeld_q && wHeld_q && !s_axi_bvalid;
   assign startCmd = wrGo && awAddr_q == `FSQ_R_CTRL && !busy_q && wData_q[2:0] != 3'h0;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         awHeld_q      <= 1'b0;
         wHeld_q       <= 1'b0;
         awAddr_q      <= 12'h000;
         wData_q       <= 32'h00000000;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else if (clkEn) begin
         s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
         end
         if (wrGo) begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_q[11:2] > `FSQ_R_POLLD >> 2) ? 2'h2 : 2'h0;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // operand registers; ignored while a flash access runs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         addr_q  <= '0;
         wdata_q <= 16'h0000;
      end else if (clkEn && wrGo && !busy_q) begin
         if (awAddr_q == `FSQ_R_ADDR) addr_q <= wData_q[AW-1:0];
         if (awAddr_q == `FSQ_R_WDATA) wdata_q <= wData_q[15:0];
      end
   end

   // =================================================================
   // AXI4-Lite read side
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end else if (clkEn) begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            unique case (s_axi_araddr)
               `FSQ_R_CTRL:  s_axi_rdata <= {29'h0, cmd_q};
               `FSQ_R_ADDR:  s_axi_rdata <= 32'(addr_q);
               `FSQ_R_WDATA: s_axi_rdata <= {16'h0000, wdata_q};
               `FSQ_R_STAT:  s_axi_rdata <= {27'h0, rbSync, result_q, done_q, busy_q};
               `FSQ_R_RDATA: s_axi_rdata <= {16'h0000, rdata_q};
               `FSQ_R_POLLD: s_axi_rdata <= polls_q;
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // =================================================================
   // flash bus cycle engine
   logic readCmd;
   logic pollEnd;
   assign readCmd = cmd_q != `FSQ_C_WRITE;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q    <= fsq_pkg::FSQ_IDLE;
         cmd_q      <= 3'h0;
         cnt_q      <= 8'h00;
         busy_q     <= 1'b0;
         chipSel_n  <= 1'b1;
         outEn_n    <= 1'b1;
         wrStrobe_n <= 1'b1;
         dataOe     <= 1'b0;
         dataOut    <= 16'h0000;
         flashAddr  <= '0;
      end else if (clkEn) begin
         unique case (state_q)
            fsq_pkg::FSQ_IDLE: if (startCmd) begin
               cmd_q     <= wData_q[2:0];
               busy_q    <= 1'b1;
               flashAddr <= addr_q;
               dataOut   <= wdata_q;
               state_q   <= fsq_pkg::FSQ_SETUP;
            end
            fsq_pkg::FSQ_SETUP: begin
               chipSel_n  <= 1'b0;
               outEn_n    <= !readCmd;
               wrStrobe_n <= readCmd;
               dataOe     <= !readCmd;
               cnt_q      <= readCmd ? 8'(`FSQ_RD_CYC) : 8'(`FSQ_WR_CYC);
               state_q    <= fsq_pkg::FSQ_STROBE;
            end
            fsq_pkg::FSQ_STROBE: if (cnt_q > 8'h01) begin
               cnt_q <= cnt_q - 8'h01;
            end else begin
               outEn_n    <= 1'b1;
               wrStrobe_n <= 1'b1;         // rising edge ends command
               state_q    <= fsq_pkg::FSQ_HOLD;
            end
            fsq_pkg::FSQ_HOLD: begin
               chipSel_n <= 1'b1;
               dataOe    <= 1'b0;
               state_q   <= fsq_pkg::FSQ_CHECK;
            end
            fsq_pkg::FSQ_CHECK: begin
               if (readCmd && !pollEnd && cmd_q != `FSQ_C_READ) begin
                  state_q <= fsq_pkg::FSQ_SETUP;
               end else begin
                  busy_q  <= 1'b0;
                  state_q <= fsq_pkg::FSQ_IDLE;
               end
            end
         endcase
      end
   end

   // =================================================================
   // polling decisions
   logic pollTrue;
   logic toggled;
   logic abortSeen;
   assign pollTrue = dataSync[`FSQ_B_POLL] == wdata_q[`FSQ_B_POLL];
   assign toggled  = havePrev_q && (dataSync[`FSQ_B_TOGGLE] != prev_q[`FSQ_B_TOGGLE]);
   // abort only counts while the poll bit is still inverted; a finished read is array data
   assign abortSeen = dataSync[`FSQ_B_ABORT] && !pollTrue;
   assign pollEnd  = (cmd_q == `FSQ_C_POLL && confirm_q)
                   || (cmd_q == `FSQ_C_POLL && dataSync[`FSQ_B_TIMEOUT] && !pollTrue)
                   || (cmd_q == `FSQ_C_TOGGLE && havePrev_q && !toggled)
                   || abortSeen
                   || polls_q >= POLL_LIMIT;

   // data sampled at the strobe end of a read, after synchroniser delay
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_q    <= 16'h0000;
         prev_q     <= 16'h0000;
         havePrev_q <= 1'b0;
         confirm_q  <= 1'b0;
         polls_q    <= 32'h00000000;
         done_q     <= 1'b0;
         result_q   <= fsq_pkg::FSQ_RES_OK;
      end else if (clkEn) begin
         if (startCmd) begin
            havePrev_q <= 1'b0;
            confirm_q  <= 1'b0;
            polls_q    <= 32'h00000000;
            done_q     <= 1'b0;
            result_q   <= fsq_pkg::FSQ_RES_OK;
         end
         if (state_q == fsq_pkg::FSQ_CHECK && readCmd) begin
            rdata_q    <= dataSync;
            prev_q     <= dataSync;
            havePrev_q <= 1'b1;
            polls_q    <= polls_q + 32'h00000001;
            if (cmd_q == `FSQ_C_POLL && pollTrue) confirm_q <= 1'b1;
         end
         if (state_q == fsq_pkg::FSQ_CHECK && (pollEnd || !readCmd || cmd_q == `FSQ_C_READ)) begin
            done_q <= 1'b1;
            if (abortSeen && cmd_q >= `FSQ_C_POLL)
               result_q <= fsq_pkg::FSQ_RES_ABORT;
            else if (polls_q >= POLL_LIMIT)
               result_q <= fsq_pkg::FSQ_RES_LIMIT;
            else if (readCmd && cmd_q != `FSQ_C_READ && dataSync[`FSQ_B_TIMEOUT] && !pollTrue)
               result_q <= fsq_pkg::FSQ_RES_TIMEOUT;
         end
      end
   end

   // =================================================================
   // checks
   property p_oe_we_exclusive;
      @(posedge core_clk) disable iff (rst) !(!outEn_n && !wrStrobe_n);
   endproperty
   a_oe_we_exclusive: assert property (p_oe_we_exclusive) else $error("oe and we both low");
   property p_no_drive_on_read;
      @(posedge core_clk) disable iff (rst) !outEn_n |-> !dataOe;
   endproperty
   a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("host drives during read");
   sequence s_strobeEnd;
      !wrStrobe_n ##1 wrStrobe_n;
   endsequence
   property p_poll_after_strobe;
      @(posedge core_clk) disable iff (rst || !clkEn) s_strobeEnd |-> outEn_n [*2];
   endproperty
   a_poll_after_strobe: assert property (p_poll_after_strobe) else $error("read before strobe end");
   property p_addr_steady;
      @(posedge core_clk) disable iff (rst) !chipSel_n |=> $stable(flashAddr);
   endproperty
   a_addr_steady: assert property (p_addr_steady) else $error("address moved during access");
   property p_strobe_needs_select;
      @(posedge core_clk) disable iff (rst) (!outEn_n || !wrStrobe_n) |-> !chipSel_n;
   endproperty
   a_strobe_needs_select: assert property (p_strobe_needs_select) else $error("strobe without select");
endmodule : fsq_host

// [tb/fsq_flash_model.sv]
// behavioural flash device: query table and write status replies
`timescale 1ns/1ps
module fsq_flash_model #(
   parameter logic [15:0] BOOT_FLAG = 16'h0002  // bottom boot variant
) (
   input  wire logic [23:0] addr,       // word address pins
   input  wire logic        ceN,        // chip select, low
   input  wire logic        oeN,        // output enable, low
   input  wire logic        weN,        // write strobe, low
   input  wire logic [15:0] hostData,   // bus value from host
   input  wire logic [2:0]  mode,       // 0 query,1 prog,2 erase,3 timeout,4 abort,5 stuck,6 protected
   input  wire logic [7:0]  busyReads,  // reads until done
   output logic      [15:0] q,          // drive value
   output logic             qOe,        // device drives bus
   output logic             rbN         // ready/busy, pulled up
);
   logic [7:0]  cnt = 8'h00;
   logic        tog = 1'b0;
   logic [15:0] pd = 16'h0000;
   logic [15:0] stat;
   logic [15:0] arr;
   logic        busy;
   // =====================================================
   // operation progress
   always @(posedge weN) if (mode != 3'h0) begin
      cnt <= busyReads;
      pd <= hostData;
   end
   always @(posedge oeN) if (!ceN) begin
      tog <= ~tog;
      if (cnt != 8'h00) cnt <= cnt - 8'h01;
   end
   assign busy = (mode >= 3'h3 && mode <= 3'h5) || (cnt > 8'h01);
   // =====================================================
   // status and query words
   always_comb begin
      stat = 16'h0000;
      stat[7] = (mode == 3'h2) ? !busy : (busy ? ~pd[7] : pd[7]);
      stat[6] = tog;
      stat[5] = (mode == 3'h3);
      stat[3] = (mode == 3'h2) && (cnt != busyReads);
      stat[2] = (mode == 3'h2) && tog;
      stat[1] = (mode == 3'h4);
      case (addr[7:0])
         8'h27: arr = 16'h0018;
         8'h28, 8'h2C, 8'h46: arr = 16'h0002;
         8'h2A: arr = 16'h0005;
         8'h2D: arr = 16'h0007;
         8'h2F: arr = 16'h0020;
         8'h31: arr = 16'h00FE;
         8'h34, 8'h47, 8'h48, 8'h4C, 8'h50: arr = 16'h0001;
         8'h40: arr = 16'h0050;
         8'h41: arr = 16'h0052;
         8'h42: arr = 16'h0049;
         8'h43: arr = 16'h0031;
         8'h44: arr = 16'h0033;
         8'h49: arr = 16'h0004;
         8'h4D: arr = 16'h00B5;
         8'h4E: arr = 16'h00C5;
         8'h4F: arr = BOOT_FLAG;
         default: arr = 16'h0000;
      endcase
      // the read right after completion still carries status in the low bits
      if (mode == 3'h0) q = arr;
      else if (busy || cnt == 8'h01) q = stat;
      else q = (mode == 3'h1) ? pd : 16'hFFFF;
   end
   assign qOe = !ceN && !oeN;
   assign rbN = busy ? 1'b0 : 1'b1;
endmodule : fsq_flash_model

// [tb/flash_status_and_query_readout_tb.sv]
// self-checking bench for the flash status and query host controller
`timescale 1ns/1ps
`include "fsq_defines.svh"
module flash_status_and_query_readout_tb;
   logic        core_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rData;
   logic [1:0]  s_axi_bresp, s_axi_rresp, bResp, rResp;
   logic [23:0] flashAddr;
   logic        chipSel_n, outEn_n, wrStrobe_n, dataOe, qOe, rbN, sawBusy, sawRbLow;
   logic [15:0] dataOut, dataIn, q, lastBus;
   logic [2:0]  mode;
   logic [7:0]  busyReads;
   int          n_errors = 0;
   int          comparisons = 0;
   // rows: word offset, expected query word
   localparam logic [23:0] QR [33] = '{24'h270018, 24'h280002, 24'h290000, 24'h2A0005, 24'h2B0000,
      24'h2C0002, 24'h2D0007, 24'h2E0000, 24'h2F0020, 24'h300000, 24'h3100FE, 24'h320000, 24'h330000,
      24'h340001, 24'h350000, 24'h3C0000, 24'h400050, 24'h410052, 24'h420049, 24'h430031, 24'h440033,
      24'h450000, 24'h460002, 24'h470001, 24'h480001, 24'h490004, 24'h4A0000, 24'h4B0000, 24'h4C0001,
      24'h4D00B5, 24'h4E00C5, 24'h4F0002, 24'h500001};
   // rows: model mode, poll command, result code, final word (all ones: not checked)
   localparam logic [2:0]  OM [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
   localparam logic [2:0]  OC [6] = '{`FSQ_C_POLL, `FSQ_C_TOGGLE, `FSQ_C_POLL, `FSQ_C_POLL, `FSQ_C_POLL,
      `FSQ_C_POLL};
   localparam logic [1:0]  OR [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
   localparam logic [31:0] OD [6] = '{32'h000000A5, 32'h0000FFFF, '1, '1, '1, 32'h0000FFFF};
   fsq_host #(.AW(24), .POLL_LIMIT(32'h00000014)) u_fsq_host (.core_clk(core_clk), .rst(rst), .clkEn(1'b1),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .flashAddr(flashAddr), .chipSel_n(chipSel_n), .outEn_n(outEn_n),
      .wrStrobe_n(wrStrobe_n), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn), .ready_busy_n(rbN));
   fsq_flash_model u_fsq_flash_model (.addr(flashAddr), .ceN(chipSel_n), .oeN(outEn_n), .weN(wrStrobe_n),
      .hostData(dataOut), .mode(mode), .busyReads(busyReads), .q(q), .qOe(qOe), .rbN(rbN));
   // an undriven bus shows the inverse of its last value, never a kind default
   assign dataIn = (dataOe === 1'b1) ? dataOut : (qOe ? q : ~lastBus);
   always @(posedge core_clk) if (dataOe === 1'b1 || qOe) lastBus <= dataIn;
   always @(posedge core_clk) if (!rst && dataOe === 1'b1 && qOe) begin
      n_errors++;
      $display("BAD bus contention expected %h seen %h", 1'b0, dataOe);
   end
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : checkVal
   task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
      logic fin;
      fin = 1'b0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!fin) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            bResp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            fin = 1'b1;
         end
      end
   endtask : axiWrite
   task automatic axiRead(input logic [11:0] a);
      logic fin;
      fin = 1'b0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!fin) begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            rData = s_axi_rdata;
            rResp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            fin = 1'b1;
         end
      end
   endtask : axiRead
   // issue a command and poll status until busy has been seen and has dropped with done
   task automatic runCmd(input logic [2:0] cmd);
      axiWrite(`FSQ_R_CTRL, {29'h0, cmd});
      sawBusy = 1'b0;
      sawRbLow = 1'b0;
      do begin
         axiRead(`FSQ_R_STAT);
         if (rData[0] === 1'b1) sawBusy = 1'b1;
         if (rData[0] === 1'b1 && rData[4] === 1'b0) sawRbLow = 1'b1;
      end while (!(sawBusy && rData[1:0] === 2'b10));
   endtask : runCmd
   task automatic finish_test();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (80000) @(posedge core_clk);
      n_errors++;
      finish_test();
   end
   initial begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      mode = 3'h0;
      busyReads = 8'h04;
      lastBus = 16'h0000;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      axiRead(`FSQ_R_STAT);
      checkVal("stat after reset", 32'h00000010, rData);
      for (int i = 0; i < 33; i++) begin
         axiWrite(`FSQ_R_ADDR, {24'h0, QR[i][23:16]});
         runCmd(`FSQ_C_READ);
         axiRead(`FSQ_R_RDATA);
         checkVal("query word", {16'h0, QR[i][15:0]}, rData);
      end
      for (int i = 0; i < 6; i++) begin
         mode <= OM[i];
         axiWrite(`FSQ_R_ADDR, 32'h00000100);
         axiWrite(`FSQ_R_WDATA, 32'h000000A5);
         runCmd(`FSQ_C_WRITE);
         runCmd(OC[i]);
         checkVal("ready busy low seen", 32'h1, {31'h0, sawRbLow});
         checkVal("poll result", {30'h0, OR[i]}, {30'h0, rData[3:2]});
         axiRead(`FSQ_R_RDATA);
         if (OD[i] != '1) checkVal("final word", OD[i], rData);
      end
      axiRead(12'h020);
      checkVal("unmapped read", 32'h80000000, {rResp, rData[29:0]});
      axiWrite(12'h020, 32'h00000001);
      checkVal("unmapped write", 32'h00000002, {30'h0, bResp});
      axiWrite(`FSQ_R_CTRL, {29'h0, `FSQ_C_POLL});
      repeat (40) @(posedge core_clk);
      rst <= 1'b1;
      mode <= 3'h0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      checkVal("pins in reset", 32'h6, {29'h0, chipSel_n, outEn_n, dataOe});
      axiRead(`FSQ_R_STAT);
      checkVal("stat after second reset", 32'h0, {28'h0, rData[3:0]});
      finish_test();
   end
endmodule : flash_status_and_query_readout_tb
